// ### tmrpw_pkg.sv
// shared constants and types for the timer / pwm / buzzer block
// assumes a classic wishbone master with 8-bit register data in the low lane
package tmrpw_pkg;

   // register byte offsets
   localparam logic [7:0] ADDR_TMR_A_COUNT = 8'h00;
   localparam logic [7:0] ADDR_TMR_A_MODE = 8'h04;
   localparam logic [7:0] ADDR_POWER_CTRL = 8'h08;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_FLAG = 8'h10;
   localparam logic [7:0] ADDR_TMR_B_CTRL_A = 8'h14;
   localparam logic [7:0] ADDR_TMR_B_CTRL_B = 8'h18;
   localparam logic [7:0] ADDR_TIMERS_HIGH = 8'h1c;
   localparam logic [7:0] ADDR_TMR_B_RELOAD_LOW = 8'h20;
   localparam logic [7:0] ADDR_PWM_DUTY_LOW = 8'h24;
   localparam logic [7:0] ADDR_BUZZER_CTRL = 8'h28;
   localparam logic [7:0] ADDR_PRESCALE_B_VALUE = 8'h2c;
   localparam logic [7:0] ADDR_TMR_B_COUNT_LOW = 8'h30;
   localparam logic [7:0] ADDR_TMR_B_COUNT_HIGH = 8'h34;

   // field positions
   localparam int MODE_LOWCLK = 7;
   localparam int MODE_SRC = 5;
   localparam int MODE_EDGE = 4;
   localparam int MODE_ASSIGN = 3;
   localparam int PCON_GIE = 7;
   localparam int PCON_RUN_A = 0;
   localparam int IRQ_A = 0;
   localparam int IRQ_B = 3;
   localparam int CA_PWM_OE = 7;
   localparam int CA_POL = 6;
   localparam int CA_SHOT = 2;
   localparam int CA_RELOAD = 1;
   localparam int CA_RUN = 0;
   localparam int CB_SRC = 5;
   localparam int CB_EDGE = 4;
   localparam int CB_PS_EN_N = 3;
   localparam int HI_RELOAD = 4;
   localparam int HI_DUTY = 0;
   localparam int BZ_EN = 7;
   localparam int BZ_FSEL_TMR = 3;

   // values after reset, and the counter end values
   localparam logic [7:0] RST_TMR_A_MODE = 8'h08;
   localparam logic [7:0] RST_CTRL_B = 8'h08;
   localparam logic [9:0] TMR_B_FULL = 10'h3ff;
   localparam logic [9:0] TMR_B_ZERO = 10'h000;
   localparam logic [7:0] TMR_A_TOP = 8'hff;

   typedef struct packed {
      logic [2:0] a;
      logic [2:0] b;
      logic [2:0] l;
   } tmrpw_sync_s;

   typedef struct packed {
      tmrpw_sync_s sync;
      logic ack;
      logic [7:0] rdat;
      logic [7:0] cnt_a;
      logic [7:0] mode_a;
      logic global_irq_en;
      logic run_a;
      logic [7:0] irq_en;
      logic flag_a;
      logic flag_b;
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic [7:0] hi_bits;
      logic [9:0] reload_buf;
      logic [9:0] duty_buf;
      logic [9:0] duty_act;
      logic [9:0] cnt_b;
      logic [7:0] ps_a;
      logic [7:0] ps_b;
      logic [7:0] bz_ctrl;
      logic [7:0] bz_div;
      logic bz_lvl;
      logic irq;
      logic pad;
      logic pad_oe;
   } tmrpw_state_s;

endpackage

// ### tmrpw_top.sv
// timer a (8-bit up), timer b (10-bit down), pwm and buzzer on one pad
// assumes clk_i is the instruction clock; count inputs are asynchronous
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
module tmrpw_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // count clock inputs
   input wire logic ext_count_clk_a_i,
   input wire logic ext_count_clk_b_i,
   input wire logic low_osc_i,
   // interrupt request and shared pad
   output logic tmr_irq_o,
   output logic shared_out_pad_o,
   output logic shared_out_pad_oe_o
);

   tmrpw_pkg::tmrpw_state_s s_q, s_d;

   function automatic logic [7:0] ratio_mask(input logic [2:0] r);
      logic [8:0] m;
      m = (9'h002 << r) - 9'h001;
      return m[7:0];
   endfunction

   function automatic logic ratio_hit(input logic [7:0] cnt,
                                      input logic [2:0] r);
      return (cnt & ratio_mask(r)) == ratio_mask(r);
   endfunction

   // edge on the second and third sync stages only
   function automatic logic edge_seen(input logic [2:0] sy,
                                      input logic fall);
      return fall ? (sy[2] & ~sy[1]) : (~sy[2] & sy[1]);
   endfunction

   logic req, wr, wr_ok;
   logic src_a, src_b, tick_a, tick_b, unf, ps_b_tick, bz_src, pwm_raw;
   logic [7:0] wd;

   always_comb begin
      s_d = s_q;
      wd = wb_dat_i[7:0];
      req = wb_cyc_i & wb_stb_i;
      // write takes effect at the edge the master sees ack
      wr = req & wb_we_i & s_q.ack;
      wr_ok = wr & wb_sel_i[0];

      // synchronisers: stage 0 read only by stage 1
      s_d.sync.a = {s_q.sync.a[1:0], ext_count_clk_a_i};
      s_d.sync.b = {s_q.sync.b[1:0], ext_count_clk_b_i};
      s_d.sync.l = {s_q.sync.l[1:0], low_osc_i};

      // edge choice on pin or low osc
      if (!s_q.mode_a[tmrpw_pkg::MODE_SRC]) begin
         src_a = 1'b1;
      end else if (s_q.mode_a[tmrpw_pkg::MODE_LOWCLK]) begin
         src_a = edge_seen(s_q.sync.l, s_q.mode_a[tmrpw_pkg::MODE_EDGE]);
      end else begin
         src_a = edge_seen(s_q.sync.a, s_q.mode_a[tmrpw_pkg::MODE_EDGE]);
      end

      // prescaler only while assign bit low
      tick_a = src_a;
      if (!s_q.mode_a[tmrpw_pkg::MODE_ASSIGN]) begin
         tick_a = src_a & ratio_hit(s_q.ps_a, s_q.mode_a[2:0]);
         if (src_a) begin
            s_d.ps_a = s_q.ps_a + 8'h01;
         end
      end

      if (tick_a && s_q.run_a) begin
         s_d.cnt_a = s_q.cnt_a + 8'h01;
         if (s_q.cnt_a == tmrpw_pkg::TMR_A_TOP) begin
            s_d.flag_a = 1'b1;
         end
      end

      src_b = s_q.ctrl_b[tmrpw_pkg::CB_SRC] ?
              edge_seen(s_q.sync.b, s_q.ctrl_b[tmrpw_pkg::CB_EDGE]) : 1'b1;

      ps_b_tick = src_b & ratio_hit(s_q.ps_b, s_q.ctrl_b[2:0]);
      tick_b = src_b;
      if (!s_q.ctrl_b[tmrpw_pkg::CB_PS_EN_N]) begin
         tick_b = ps_b_tick;
         if (src_b) begin
            s_d.ps_b = s_q.ps_b + 8'h01;
         end
      end

      unf = 1'b0;
      if (tick_b && s_q.ctrl_a[tmrpw_pkg::CA_RUN]) begin
         if (s_q.cnt_b == tmrpw_pkg::TMR_B_ZERO) begin
            unf = 1'b1;
            s_d.flag_b = 1'b1;
            // new duty takes effect at underflow
            s_d.duty_act = s_q.duty_buf;
            if (s_q.ctrl_a[tmrpw_pkg::CA_SHOT]) begin
               s_d.ctrl_a[tmrpw_pkg::CA_RUN] = 1'b0;
            end else if (s_q.ctrl_a[tmrpw_pkg::CA_RELOAD]) begin
               s_d.cnt_b = s_q.reload_buf;
            end else begin
               s_d.cnt_b = tmrpw_pkg::TMR_B_FULL;
            end
         end else begin
            s_d.cnt_b = s_q.cnt_b - 10'h001;
         end
      end

      bz_src = s_q.bz_ctrl[tmrpw_pkg::BZ_FSEL_TMR] ? unf : ps_b_tick;
      if (bz_src) begin
         s_d.bz_div = s_q.bz_div + 8'h01;
         if (ratio_hit(s_q.bz_div, s_q.bz_ctrl[2:0])) begin
            s_d.bz_lvl = ~s_q.bz_lvl;
         end
      end

      pwm_raw = s_q.ctrl_a[tmrpw_pkg::CA_RUN] & (s_q.cnt_b < s_q.duty_act);

      // register writes; hardware set above wins over a clear
      if (wr_ok) begin
         unique case (wb_adr_i)
            tmrpw_pkg::ADDR_TMR_A_COUNT: begin
               s_d.cnt_a = wd;
            end
            tmrpw_pkg::ADDR_TMR_A_MODE: begin
               s_d.mode_a = wd;
               if (!wd[tmrpw_pkg::MODE_ASSIGN]) begin
                  s_d.ps_a = 8'h00;
               end
            end
            tmrpw_pkg::ADDR_POWER_CTRL: begin
               s_d.global_irq_en = wd[tmrpw_pkg::PCON_GIE];
               s_d.run_a = wd[tmrpw_pkg::PCON_RUN_A];
            end
            tmrpw_pkg::ADDR_IRQ_ENABLE: begin
               s_d.irq_en = wd;
            end
            tmrpw_pkg::ADDR_IRQ_FLAG: begin
               s_d.flag_a = s_d.flag_a |
                            (s_q.flag_a & wd[tmrpw_pkg::IRQ_A]);
               if (!(tick_a && s_q.run_a && s_q.cnt_a == 8'hff)) begin
                  s_d.flag_a = s_q.flag_a & wd[tmrpw_pkg::IRQ_A];
               end
               s_d.flag_b = unf | (s_q.flag_b & wd[tmrpw_pkg::IRQ_B]);
            end
            tmrpw_pkg::ADDR_TMR_B_CTRL_A: begin
               s_d.ctrl_a = wd;
            end
            tmrpw_pkg::ADDR_TMR_B_CTRL_B: begin
               s_d.ctrl_b = wd;
            end
            tmrpw_pkg::ADDR_TIMERS_HIGH: begin
               s_d.hi_bits = wd;
            end
            tmrpw_pkg::ADDR_TMR_B_RELOAD_LOW: begin
               s_d.reload_buf = {s_q.hi_bits[tmrpw_pkg::HI_RELOAD +: 2], wd};
               if (!s_q.ctrl_a[tmrpw_pkg::CA_RUN]) begin
                  s_d.cnt_b = {s_q.hi_bits[tmrpw_pkg::HI_RELOAD +: 2], wd};
               end
            end
            tmrpw_pkg::ADDR_PWM_DUTY_LOW: begin
               s_d.duty_buf = {s_q.hi_bits[tmrpw_pkg::HI_DUTY +: 2], wd};
            end
            tmrpw_pkg::ADDR_BUZZER_CTRL: begin
               s_d.bz_ctrl = wd;
            end
            default: begin
            end
         endcase
      end

      // registered answer; ack drops the cycle after it is given
      s_d.ack = req & ~s_q.ack;
      if (req && !s_q.ack) begin
         unique case (wb_adr_i)
            tmrpw_pkg::ADDR_TMR_A_COUNT: s_d.rdat = s_q.cnt_a;
            tmrpw_pkg::ADDR_TMR_A_MODE: s_d.rdat = s_q.mode_a;
            tmrpw_pkg::ADDR_POWER_CTRL:
               s_d.rdat = {s_q.global_irq_en, 6'h00, s_q.run_a};
            tmrpw_pkg::ADDR_IRQ_ENABLE: s_d.rdat = s_q.irq_en;
            tmrpw_pkg::ADDR_IRQ_FLAG:
               s_d.rdat = {4'h0, s_q.flag_b, 2'h0, s_q.flag_a};
            tmrpw_pkg::ADDR_TMR_B_CTRL_A: s_d.rdat = s_q.ctrl_a;
            tmrpw_pkg::ADDR_TMR_B_CTRL_B: s_d.rdat = s_q.ctrl_b;
            tmrpw_pkg::ADDR_TIMERS_HIGH: s_d.rdat = s_q.hi_bits;
            tmrpw_pkg::ADDR_TMR_B_RELOAD_LOW: s_d.rdat = s_q.cnt_b[7:0];
            tmrpw_pkg::ADDR_PWM_DUTY_LOW: s_d.rdat = s_q.duty_buf[7:0];
            tmrpw_pkg::ADDR_BUZZER_CTRL: s_d.rdat = s_q.bz_ctrl;
            tmrpw_pkg::ADDR_PRESCALE_B_VALUE: s_d.rdat = s_q.ps_b;
            tmrpw_pkg::ADDR_TMR_B_COUNT_LOW: s_d.rdat = s_q.cnt_b[7:0];
            tmrpw_pkg::ADDR_TMR_B_COUNT_HIGH:
               s_d.rdat = {6'h00, s_q.cnt_b[9:8]};
            default: s_d.rdat = 8'h00;
         endcase
      end

      // timer a request gated by enables
      // timer b request gated by enables
      s_d.irq = s_q.global_irq_en & ((s_q.flag_a & s_q.irq_en[tmrpw_pkg::IRQ_A]) |
                           (s_q.flag_b & s_q.irq_en[tmrpw_pkg::IRQ_B]));

      // pwm before buzzer on the pad
      if (s_q.ctrl_a[tmrpw_pkg::CA_PWM_OE]) begin
         s_d.pad = pwm_raw ^ s_q.ctrl_a[tmrpw_pkg::CA_POL];
         s_d.pad_oe = 1'b1;
      end else if (s_q.bz_ctrl[tmrpw_pkg::BZ_EN]) begin
         s_d.pad = s_q.bz_lvl;
         s_d.pad_oe = 1'b1;
      end else begin
         s_d.pad = 1'b0;
         s_d.pad_oe = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.mode_a <= tmrpw_pkg::RST_TMR_A_MODE;
         s_q.ctrl_b <= tmrpw_pkg::RST_CTRL_B;
         s_q.cnt_b <= tmrpw_pkg::TMR_B_FULL;
         s_q.reload_buf <= tmrpw_pkg::TMR_B_FULL;
      end else begin
         s_q <= s_d;
      end
   end

   assign wb_dat_o = {24'h000000, s_q.rdat};
   assign wb_ack_o = s_q.ack;
   assign tmr_irq_o = s_q.irq;
   assign shared_out_pad_o = s_q.pad;
   assign shared_out_pad_oe_o = s_q.pad_oe;

endmodule // tmrpw_top

// ### tmrpw_monitor.sv
// checker on the timer / pwm / buzzer top ports
// assumes one clock and a synchronous active-high reset
module tmrpw_monitor (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // outputs
   input wire logic tmr_irq_o,
   input wire logic shared_out_pad_o,
   input wire logic shared_out_pad_oe_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic wr_hit;
   logic oe_want;
   logic pwm_q;
   logic bz_q;
   logic gie_q;
   assign wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign oe_want = pwm_q | bz_q;
   // shadow of the enables, updated at the write's ack edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwm_q <= 1'b0;
         bz_q <= 1'b0;
         gie_q <= 1'b0;
      end else if (wr_hit) begin
         if (wb_adr_i == 8'h14) pwm_q <= wb_dat_i[7];
         if (wb_adr_i == 8'h28) bz_q <= wb_dat_i[7];
         if (wb_adr_i == 8'h08) gie_q <= wb_dat_i[7];
      end
   end
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   a_ack_answer: assert property (s_req |=> wb_ack_o)
      else $error("request not acked");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_read_width: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_oe_on: assert property (oe_want [*3] |-> shared_out_pad_oe_o)
      else $error("pad not driven");
   a_oe_off: assert property (!oe_want [*3] |-> !shared_out_pad_oe_o)
      else $error("pad driven while off");
   a_irq_gate: assert property (!gie_q [*2] |-> !tmr_irq_o)
      else $error("irq without global enable");
   a_reset_quiet: assert property ($past(rst_i) |-> !wb_ack_o && !tmr_irq_o && !shared_out_pad_oe_o)
      else $error("outputs active after reset");
endmodule // tmrpw_monitor

bind tmrpw_top tmrpw_monitor tmrpw_monitor_inst (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .tmr_irq_o(tmr_irq_o),
   .shared_out_pad_o(shared_out_pad_o),
   .shared_out_pad_oe_o(shared_out_pad_oe_o)
);

// ### tmrpw_partner.sv
// partner: count pins, low oscillator and the output pad
// assumes clk_i is the bench clock; pins stand still between bursts
module tmrpw_partner (
   // clock
   input wire logic clk_i,
   // count sources
   output logic ext_a_o,
   output logic ext_b_o,
   output logic low_osc_o,
   // pad
   input wire logic pad_i,
   input wire logic pad_oe_i
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      ext_a_o = 1'b0;
      ext_b_o = 1'b0;
      low_osc_o = 1'b0;
   end
   // toggles pin a, pin b or the low oscillator
   // each level held half clocks, well above the synchroniser delay
   task automatic toggle(input int src, input int n, input int half);
      for (int k = 0; k < n; k++) begin
         repeat (half) @(posedge clk_i);
         if (src == 0) ext_a_o <= ~ext_a_o;
         else if (src == 1) ext_b_o <= ~ext_b_o;
         else low_osc_o <= ~low_osc_o;
      end
   endtask
   task automatic count_high(input int n, output int hi);
      hi = 0;
      repeat (n) begin
         @(posedge clk_i);
         if (pad_oe_i === 1'b1 && pad_i === 1'b1) hi++;
      end
   endtask
endmodule // tmrpw_partner

// ### tmrpw_bench.sv
// self-checking bench for the timer / pwm / buzzer block
// assumes the partner model drives count pins and watches the pad
module tmrpw_bench;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [7:0] adr;
      logic [7:0] wd;
      logic [7:0] exp;
   } tmrpw_row_s;
   localparam tmrpw_row_s ROWS [7] = '{'{8'h04, 8'hbf, 8'hbf},
      '{8'h0c, 8'h09, 8'h09}, '{8'h18, 8'h3a, 8'h3a},
      '{8'h1c, 8'h33, 8'h33}, '{8'h28, 8'h0b, 8'h0b},
      '{8'h3c, 8'h55, 8'h00}, '{8'h2c, 8'h55, 8'h00}};
   logic clk_i;
   logic rst_i;
   logic wb_cyc_i;
   logic wb_stb_i;
   logic wb_we_i;
   logic [7:0] wb_adr_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic ext_a;
   logic ext_b;
   logic low_osc;
   logic irq;
   logic pad;
   logic pad_oe;
   logic [7:0] rd;
   int error_cnt;
   int n_tests;
   int cyc_cnt;
   int hi;
   tmrpw_top tmrpw_top_inst (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_count_clk_a_i(ext_a),
      .ext_count_clk_b_i(ext_b), .low_osc_i(low_osc), .tmr_irq_o(irq),
      .shared_out_pad_o(pad), .shared_out_pad_oe_o(pad_oe));
   tmrpw_partner tmrpw_partner_inst (.clk_i(clk_i), .ext_a_o(ext_a),
      .ext_b_o(ext_b), .low_osc_o(low_osc), .pad_i(pad), .pad_oe_i(pad_oe));
   task automatic check(input string what, input logic [7:0] got,
                        input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // holds the request until ack, then a cycle idle
   task automatic wb_x(input logic [7:0] a, input logic we, input logic [7:0] d,
                       output logic [7:0] r);
      int t;
      t = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
         t++;
      end while (wb_ack_o !== 1'b1 && t < 20);
      if (t >= 20) error_cnt++;
      r = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wb_w(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      wb_x(a, 1'b1, d, r);
   endtask
   task automatic rd_chk(input string w, input logic [7:0] a,
                         input logic [7:0] e);
      wb_x(a, 1'b0, 8'h00, rd);
      check(w, rd, e);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         final_report();
      end
   end
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
      {error_cnt, n_tests, cyc_cnt} = '0;
      rst_i = 1'b1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd_chk("mode a reset", 8'h04, 8'h08);
      rd_chk("ctrl b reset", 8'h18, 8'h08);
      rd_chk("count b high", 8'h34, 8'h03);
      foreach (ROWS[i]) begin
         wb_w(ROWS[i].adr, ROWS[i].wd);
         rd_chk("register", ROWS[i].adr, ROWS[i].exp);
      end
      $display("registers done");
      wb_w(8'h1c, 8'h00);
      wb_w(8'h28, 8'h00);
      wb_w(8'h18, 8'h08);
      wb_w(8'h20, 8'h05);
      rd_chk("stopped load", 8'h20, 8'h05);
      wb_w(8'h0c, 8'h08);
      wb_w(8'h08, 8'h80);
      wb_w(8'h14, 8'h05);
      repeat (20) @(posedge clk_i);
      rd_chk("shot count", 8'h20, 8'h00);
      rd_chk("shot stop", 8'h14, 8'h04);
      rd_chk("underflow flag", 8'h10, 8'h08);
      check("irq b", {7'h0, irq}, 8'h01);
      wb_w(8'h10, 8'h00);
      rd_chk("flag clear", 8'h10, 8'h00);
      check("irq clear", {7'h0, irq}, 8'h00);
      wb_w(8'h18, 8'h28);
      wb_w(8'h20, 8'h05);
      wb_w(8'h14, 8'h01);
      tmrpw_partner_inst.toggle(1, 3, 4);
      repeat (6) @(posedge clk_i);
      rd_chk("pin rising", 8'h20, 8'h03);
      wb_w(8'h18, 8'h38);
      tmrpw_partner_inst.toggle(1, 1, 4);
      repeat (6) @(posedge clk_i);
      rd_chk("pin falling", 8'h20, 8'h02);
      // prescaler b on, 1:2 on rising pin edges
      wb_w(8'h18, 8'h20);
      tmrpw_partner_inst.toggle(1, 8, 4);
      repeat (6) @(posedge clk_i);
      rd_chk("prescale b value", 8'h2c, 8'h04);
      rd_chk("prescale b count", 8'h20, 8'h00);
      $display("timer b done");
      wb_w(8'h14, 8'h00);
      wb_w(8'h00, 8'hfe);
      wb_w(8'h04, 8'h38);
      wb_w(8'h08, 8'h81);
      tmrpw_partner_inst.toggle(0, 5, 4);
      repeat (6) @(posedge clk_i);
      rd_chk("overflow count", 8'h00, 8'h00);
      rd_chk("overflow flag", 8'h10, 8'h01);
      check("irq masked", {7'h0, irq}, 8'h00);
      wb_w(8'h0c, 8'h09);
      // request is registered one edge after the enable lands
      @(posedge clk_i);
      check("irq a", {7'h0, irq}, 8'h01);
      wb_w(8'h04, 8'ha8);
      wb_w(8'h00, 8'h00);
      tmrpw_partner_inst.toggle(2, 5, 8);
      repeat (6) @(posedge clk_i);
      rd_chk("low osc", 8'h00, 8'h03);
      wb_w(8'h04, 8'h21);
      wb_w(8'h00, 8'h00);
      tmrpw_partner_inst.toggle(0, 16, 4);
      repeat (6) @(posedge clk_i);
      rd_chk("prescale four", 8'h00, 8'h02);
      $display("timer a done");
      wb_w(8'h08, 8'h00);
      wb_w(8'h18, 8'h08);
      wb_w(8'h20, 8'h08);
      wb_w(8'h24, 8'h04);
      wb_w(8'h28, 8'h80);
      wb_w(8'h14, 8'h83);
      tmrpw_partner_inst.count_high(8, hi);
      check("duty deferred", hi[7:0], 8'h00);
      check("pad output", {7'h0, pad_oe}, 8'h01);
      repeat (30) @(posedge clk_i);
      tmrpw_partner_inst.count_high(90, hi);
      check("pwm high", hi[7:0], 8'h28);
      wb_w(8'h14, 8'hc3);
      repeat (20) @(posedge clk_i);
      tmrpw_partner_inst.count_high(90, hi);
      check("pwm inverted", hi[7:0], 8'h32);
      wb_w(8'h14, 8'h81);
      repeat (20) @(posedge clk_i);
      rd_chk("restart full", 8'h34, 8'h03);
      // stop and reload so underflows come every nine cycles
      wb_w(8'h14, 8'h00);
      wb_w(8'h20, 8'h08);
      wb_w(8'h14, 8'h03);
      wb_w(8'h28, 8'h88);
      repeat (40) @(posedge clk_i);
      tmrpw_partner_inst.count_high(72, hi);
      check("buzzer high", hi[7:0], 8'h24);
      // mid-run reset with buzzer driving and flags set
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check("pad after reset", {7'h0, pad_oe}, 8'h00);
      rd_chk("count b after reset", 8'h34, 8'h03);
      rd_chk("flags after reset", 8'h10, 8'h00);
      $display("reset done");
      wb_w(8'h28, 8'h00);
      wb_w(8'h14, 8'h00);
      $display("pwm and buzzer done");
      final_report();
   end
endmodule // tmrpw_bench
